// ===== scdi_pkg.sv
// Purpose: Constants and types for the serial codec control/status block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Offsets and field positions shared by design and bench
package scdi_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CTL = 8'h04;
  localparam logic [7:0] OFS_TXD = 8'h08;
  localparam logic [7:0] OFS_CTX = 8'h0C;
  localparam logic [7:0] OFS_CRX = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_IER = 8'h18;
  localparam logic [7:0] OFS_SLOT = 8'h1C;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODE_FL_MSB = 3;
  localparam int MODE_W = 4;
  localparam int CTL_TXE = 0;
  localparam int CTL_RXE = 1;
  localparam int CTL_STOP = 2;
  localparam int CTL_W = 3;
  localparam int ST_RSVD = 15;
  localparam int ST_CTRL_TX_READY_FLAG = 14;
  localparam int ST_TX_FIFO_EMPTY_FLAG = 13;
  localparam int ST_W = 16;
  localparam int SLOT_W = 3;
  localparam int WORD_W = 16;
  localparam int BIT_W = 4;
  localparam logic [SLOT_W-1:0] DATA_SLOT = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h0;
  localparam logic [BIT_W-1:0] BIT_FIRST = 4'h0;
  localparam logic [BIT_W-1:0] BIT_LAST = 4'hF;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Slot position register layout, low half channel 1, high half channel 0
  typedef struct packed {
    logic [2:0] pad0;
    logic ch0_en;
    logic ch0_gap;
    logic [SLOT_W-1:0] ch0_pos;
    logic [2:0] pad1;
    logic ch1_en;
    logic ch1_gap;
    logic [SLOT_W-1:0] ch1_pos;
  } scdi_slot_cfg_t;
  typedef struct packed {
    logic rsvd;
    logic ctrl_tx_ready_flag;
    logic tx_fifo_empty_flag;
    logic [12:0] none;
  } scdi_stat_t;
endpackage

// ===== scdi_ctrl_status.sv
// Purpose: Control-channel receive data and transmit status of a serial codec port
// Assumes: APB slave, serial pins synchronous to clk, one bit per clock
// Notes: Frame of 2**SLOT_W slots of 16 bits, MSB first
//
// What this block does
// - Control receive data usable only with frame-length MSB set
// - Channel 0 word captured into bits 31..16
// - Channel 1 word captured into bits 15..0
// - Channel slots come from slot-position fields
// - Channel 0 data valid only when enabled
// - Channel 1 data valid only when enabled
// - Sixteen-bit read-only status register
// - Enabled status bits raise the interrupt
// - Status returns to initial values in stop
// - Status bit 15 reads zero, write zero
// - Bit 14 shows control transmit write allowed
// - Overwrite while not ready discards old word
// - Control-ready meaningful only with transmit enabled
// - Control transmit write clears control-ready
// - Bit 13 shows transmit FIFO empty
// - FIFO-empty meaningful only with transmit enabled
// - Transmit data write clears FIFO-empty
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module scdi_ctrl_status
  import scdi_pkg::*;
#(
  parameter int DEPTH = 2
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic frame_sync,
  output logic irq
);
  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [MODE_W-1:0] mode_reg_q;
  logic [CTL_W-1:0] control_reg_q;
  scdi_slot_cfg_t slot_q;
  logic [ST_W-1:0] ier_q;
  logic [31:0] ctrl_tx_q;
  logic [31:0] ctrl_cur_q;
  logic ctrl_pend_q;
  logic [WORD_W-1:0] rx0_q;
  logic [WORD_W-1:0] rx1_q;
  logic ctrl_tx_ready_flag_q;
  logic tx_fifo_empty_flag_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic access;
  logic done;
  logic stall;
  logic mapped;
  logic fifo_full;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_head;
  logic [1:0] fifo_cnt_q;
  logic wr_ctx;
  logic wr_txd;
  logic transmit_enable;
  logic stop;
  logic fl_ok;
  scdi_stat_t stat;
  logic [31:0] rd_d;
  assign transmit_enable = control_reg_q[CTL_TXE];
  assign stop = control_reg_q[CTL_STOP];
  assign fl_ok = mode_reg_q[MODE_FL_MSB];
  assign access = psel && penable;
  assign stall = access && pwrite && (paddr == OFS_TXD) && fifo_full;
  assign done = access && pready_q;
  assign wr_ctx = done && pwrite && (paddr == OFS_CTX) && fl_ok;
  assign wr_txd = done && pwrite && (paddr == OFS_TXD) && !stop;
  assign mapped = (paddr == OFS_MODE) || (paddr == OFS_CTL) || (paddr == OFS_TXD)
    || (paddr == OFS_CTX) || (paddr == OFS_CRX) || (paddr == OFS_STAT)
    || (paddr == OFS_IER) || (paddr == OFS_SLOT);
  // Flags shown only while transmit is enabled
  always_comb
  begin
    stat = '0;
    stat.rsvd = 1'b0;
    stat.ctrl_tx_ready_flag = ctrl_tx_ready_flag_q && transmit_enable;
    stat.tx_fifo_empty_flag = tx_fifo_empty_flag_q && transmit_enable;
  end

  always_comb
  begin
    rd_d = RST_WORD;
    case (paddr)
      OFS_MODE: rd_d[MODE_W-1:0] = mode_reg_q;
      OFS_CTL: rd_d[CTL_W-1:0] = control_reg_q;
      OFS_CTX: rd_d = ctrl_tx_q;
      OFS_CRX: rd_d = fl_ok ? {rx0_q, rx1_q} : RST_WORD;
      OFS_STAT: rd_d[ST_W-1:0] = stat;
      OFS_IER: rd_d[ST_W-1:0] = ier_q;
      OFS_SLOT: rd_d = {16'h0000, slot_q};
      default: rd_d = RST_WORD;
    endcase
  end

  // Answer one cycle into the access phase, held off while a transmit data write finds the FIFO full
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RST_WORD;
    end
    else
    begin
      pready_q <= access && !pready_q && !stall;
      pslverr_q <= access && !pready_q && !stall && !mapped;
      prdata_q <= (access && !pready_q && !pwrite) ? rd_d : RST_WORD;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mode_reg_q <= '0;
      control_reg_q <= '0;
      slot_q <= '0;
      ier_q <= '0;
    end
    else if (done && pwrite)
    begin
      case (paddr)
        OFS_MODE: mode_reg_q <= pwdata[MODE_W-1:0];
        OFS_CTL: control_reg_q <= pwdata[CTL_W-1:0];
        OFS_SLOT: slot_q <= pwdata[15:0];
        OFS_IER: ier_q <= pwdata[ST_W-1:0];
        default: ier_q <= ier_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame timing and serial shifters
  // ---------------------------------------------------------------
  logic run;
  logic [BIT_W-1:0] bit_q;
  logic [SLOT_W-1:0] slot_cnt_q;
  logic [WORD_W-1:0] tx_sh_q;
  logic [WORD_W-1:0] rx_sh_q;
  logic [WORD_W-1:0] rx_word;
  logic [WORD_W-1:0] tx_word;
  logic [31:0] ctrl_src;
  logic slot_start;
  logic frame_start;
  logic hit0;
  logic hit1;
  logic pop;
  logic cap0;
  logic cap1;

  assign run = (transmit_enable || control_reg_q[CTL_RXE]) && !stop;
  assign slot_start = run && (bit_q == BIT_FIRST);
  assign frame_start = slot_start && (slot_cnt_q == SLOT_FIRST);
  assign hit0 = fl_ok && slot_q.ch0_en && (slot_cnt_q == slot_q.ch0_pos);
  assign hit1 = fl_ok && slot_q.ch1_en && (slot_cnt_q == slot_q.ch1_pos);
  assign rx_word = {rx_sh_q[WORD_W-2:0], serial_rx_pin};
  assign cap0 = run && control_reg_q[CTL_RXE] && (bit_q == BIT_LAST) && hit0;
  assign cap1 = run && control_reg_q[CTL_RXE] && (bit_q == BIT_LAST) && hit1;
  assign ctrl_src = (frame_start && ctrl_pend_q && transmit_enable) ? ctrl_tx_q : ctrl_cur_q;
  assign pop = slot_start && transmit_enable && !hit0 && !hit1
    && (slot_cnt_q == DATA_SLOT) && fifo_valid;
  always_comb
  begin
    tx_word = '0;
    if (hit0)
      tx_word = ctrl_src[31:16];
    else if (hit1)
      tx_word = ctrl_src[15:0];
    else if (pop)
      tx_word = fifo_head;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst || !run)
    begin
      bit_q <= BIT_FIRST;
      slot_cnt_q <= SLOT_FIRST;
    end
    else
    begin
      bit_q <= bit_q + 1'b1;
      if (bit_q == BIT_LAST)
      begin
        slot_cnt_q <= slot_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      tx_sh_q <= '0;
      serial_tx_pin <= 1'b0;
      frame_sync <= 1'b0;
    end
    else
    begin
      frame_sync <= frame_start;
      if (slot_start && transmit_enable)
      begin
        serial_tx_pin <= tx_word[WORD_W-1];
        tx_sh_q <= {tx_word[WORD_W-2:0], 1'b0};
      end
      else
      begin
        serial_tx_pin <= run && transmit_enable && tx_sh_q[WORD_W-1];
        tx_sh_q <= {tx_sh_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rx_sh_q <= '0;
      rx0_q <= '0;
      rx1_q <= '0;
    end
    else
    begin
      rx_sh_q <= rx_word;
      if (cap0)
        rx0_q <= rx_word;
      if (cap1)
        rx1_q <= rx_word;
    end
  end
  // ---------------------------------------------------------------
  // Control transmit word and ready flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst || stop)
    begin
      ctrl_tx_q <= RST_WORD;
      ctrl_cur_q <= RST_WORD;
      ctrl_pend_q <= 1'b0;
    end
    else
    begin
      if (frame_start && transmit_enable && ctrl_pend_q)
        ctrl_cur_q <= ctrl_tx_q;
      if (wr_ctx)
      begin
        ctrl_tx_q <= pwdata;
        ctrl_pend_q <= 1'b1;
      end
      else if (frame_start && transmit_enable)
        ctrl_pend_q <= 1'b0;
    end
  end
  // Write wins over the frame-start set: a new word is pending again
  always_ff @(posedge clk)
  begin
    if (!nrst || stop)
      ctrl_tx_ready_flag_q <= 1'b0;
    else if (wr_ctx)
      ctrl_tx_ready_flag_q <= 1'b0;
    else if (frame_start && transmit_enable)
      ctrl_tx_ready_flag_q <= 1'b1;
  end
  // ---------------------------------------------------------------
  // Transmit data buffer
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] mem_q [DEPTH];
  logic [0:0] wp_q;
  logic [0:0] rp_q;

  assign fifo_full = (fifo_cnt_q == 2'(DEPTH));
  assign fifo_valid = (fifo_cnt_q != 2'h0);
  assign fifo_head = mem_q[rp_q];

  always_ff @(posedge clk)
  begin
    if (!nrst || stop)
    begin
      wp_q <= '0;
      rp_q <= '0;
      fifo_cnt_q <= 2'h0;
    end
    else
    begin
      if (wr_txd)
      begin
        mem_q[wp_q] <= pwdata[WORD_W-1:0];
        wp_q <= wp_q + 1'b1;
      end
      if (pop)
        rp_q <= rp_q + 1'b1;
      fifo_cnt_q <= fifo_cnt_q + 2'(wr_txd) - 2'(pop);
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst || stop)
      tx_fifo_empty_flag_q <= 1'b0;
    else if (wr_txd)
      tx_fifo_empty_flag_q <= 1'b0;
    else if (pop && (fifo_cnt_q == 2'h1))
      tx_fifo_empty_flag_q <= 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(stat & ier_q);
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_ctx_write;
    wr_ctx && !stop;
  endsequence
  sequence s_last_pop;
    pop && (fifo_cnt_q == 2'h1) && !wr_txd && !stop;
  endsequence

  chk_rx_mode_gate: assert property ($changed(rx0_q) || $changed(rx1_q) |-> $past(fl_ok))
    else $error("receive word changed without frame length mode");
  chk_rx0_capture: assert property (cap0 |=> rx0_q == $past(rx_word))
    else $error("channel 0 word not captured");
  chk_rx1_enable: assert property ($changed(rx1_q) |-> $past(slot_q.ch1_en))
    else $error("channel 1 word captured while disabled");
  chk_stat_rsvd: assert property (done && !pwrite && paddr == OFS_STAT |-> !prdata_q[ST_RSVD])
    else $error("reserved status bit read as one");
  chk_ctrl_tx_ready_flag_clear: assert property (s_ctx_write |=> !ctrl_tx_ready_flag_q ##1
    (!ctrl_tx_ready_flag_q || $past(frame_start)))
    else $error("control ready not cleared by write");
  chk_ctrl_tx_ready_flag_set: assert property (frame_start && transmit_enable && !wr_ctx && !stop |=> ctrl_tx_ready_flag_q)
    else $error("control ready not set when word taken");
  chk_tx_fifo_empty_flag_set: assert property (s_last_pop |=> tx_fifo_empty_flag_q && fifo_cnt_q == 2'h0)
    else $error("fifo empty flag not set after last word");
  chk_tx_fifo_empty_flag_clear: assert property (wr_txd |=> !tx_fifo_empty_flag_q && fifo_valid)
    else $error("fifo empty flag not cleared by write");
  chk_stop_init: assert property (stop |=> !ctrl_tx_ready_flag_q && !tx_fifo_empty_flag_q)
    else $error("status not initial in stop");
  chk_irq_source: assert property (##1 irq == $past(|(stat & ier_q)))
    else $error("interrupt does not follow enabled status");
endmodule
`default_nettype wire

// ===== scdi_codec_model.sv
// Purpose: Codec model on the serial pins
// Assumes: Slots of 16 bits, MSB first, transmit slot 0 starts with frame_sync
// Notes: Receive bits lead frame_sync by one clock; line toggles outside frames
`timescale 1ns/1ns
`default_nettype none
module scdi_codec_model
  import scdi_pkg::*;
(
  input wire logic clk,
  input wire logic frame_sync,
  input wire logic serial_tx_pin,
  input wire logic [15:0] rx_words [8],
  output logic serial_rx_pin,
  output logic [15:0] tx_words [8]
);
  logic [7:0] cnt_q = 8'h80;
  logic [6:0] pos;
  logic [6:0] nxt;
  logic live;
  logic last_q = 1'b0;
  assign pos = frame_sync ? 7'h00 : cnt_q[6:0];
  // Block samples receive bit n while transmit bit n-1 is out
  assign nxt = pos + 7'h01;
  assign live = frame_sync || !cnt_q[7];
  // Undriven line must not look like held data
  always_comb
  begin
    if (live)
      serial_rx_pin = rx_words[nxt[6:4]][4'hF - nxt[3:0]];
    else
      serial_rx_pin = ~last_q;
  end
  always_ff @(posedge clk)
  begin
    last_q <= serial_rx_pin;
    cnt_q <= live ? {1'b0, pos} + 8'h01 : 8'h80;
    if (live)
      tx_words[pos[6:4]] <= {tx_words[pos[6:4]][14:0], serial_tx_pin};
  end
endmodule
`default_nettype wire

// ===== scdi_ctrl_status_test.sv
// Purpose: Self-checking bench for the control/status block
// Assumes: APB master, codec model on the serial pins
// Notes: Scenarios align to frame_sync to avoid frame-start races
`timescale 1ns/1ns
`default_nettype none
module scdi_ctrl_status_test
  import scdi_pkg::*;
;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic rxp, txp, fs, irq, rerr;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] rxw [8];
  logic [15:0] txw [8];
  int miscompares, tests_run;

  scdi_ctrl_status u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_rx_pin(rxp), .serial_tx_pin(txp), .frame_sync(fs),
    .irq(irq));
  scdi_codec_model u_codec (.clk(clk), .frame_sync(fs), .serial_tx_pin(txp),
    .rx_words(rxw), .serial_rx_pin(rxp), .tx_words(txw));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task complete_run;
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task fail(input string m);
    miscompares++;
    $display("wrong value at %0t: %s", $time, m);
    complete_run();
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 300);
    if (pready !== 1'b1)
      fail("no pready");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e, "read");
  endtask

  task wsync;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (fs !== 1'b1 && n < 300);
    if (fs !== 1'b1)
      fail("no frame");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset;
    rdc(OFS_CRX, RST_WORD);
    rdc(OFS_STAT, 32'h0000_0000);
    wr(OFS_CRX, 32'hFFFF_FFFF);
    rdc(OFS_CRX, RST_WORD);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001, "unmapped");
  endtask

  task t_flags;
    wr(OFS_MODE, 32'h0000_0008);
    wr(OFS_IER, 32'h0000_6000);
    wr(OFS_CTL, 32'h0000_0001);
    wr(OFS_TXD, 32'h0000_1234);
    wsync();
    wsync();
    rdc(OFS_STAT, 32'h0000_6000);
    chk({31'h0, irq}, 32'h0000_0001, "irq set");
    wr(OFS_CTX, 32'h0000_0000);
    wr(OFS_TXD, 32'h0000_0000);
    rdc(OFS_STAT, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000, "irq clear");
    wsync();
    wr(OFS_IER, 32'h0000_0000);
    rdc(OFS_STAT, 32'h0000_6000);
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    wr(OFS_CTL, 32'h0000_0000);
    rdc(OFS_STAT, 32'h0000_0000);
  endtask

  task t_ctx;
    wr(OFS_CTL, 32'h0000_0001);
    wr(OFS_SLOT, 32'h0000_1215);
    wsync();
    wr(OFS_CTX, 32'h1111_2222);
    wr(OFS_CTX, 32'hABCD_1234);
    wsync();
    wsync();
    chk({16'h0, txw[2]}, 32'h0000_ABCD, "ch0 tx");
    chk({16'h0, txw[5]}, 32'h0000_1234, "ch1 tx");
  endtask

  task t_crx;
    rxw[2] <= 16'h5A3C;
    rxw[5] <= 16'hC3A5;
    wr(OFS_CTL, 32'h0000_0003);
    wsync();
    wsync();
    rdc(OFS_CRX, 32'h5A3C_C3A5);
    wr(OFS_SLOT, 32'h0000_1205);
    rxw[2] <= 16'h0F0F;
    rxw[5] <= 16'h7E81;
    wsync();
    wsync();
    rdc(OFS_CRX, 32'h0F0F_C3A5);
    wr(OFS_SLOT, 32'h0000_0215);
    rxw[2] <= 16'h9999;
    rxw[5] <= 16'h6666;
    wsync();
    wsync();
    rdc(OFS_CRX, 32'h0F0F_6666);
    wr(OFS_MODE, 32'h0000_0000);
    rdc(OFS_CRX, 32'h0000_0000);
  endtask

  task t_stop;
    wr(OFS_MODE, 32'h0000_0008);
    wr(OFS_CTL, 32'h0000_0001);
    wsync();
    wr(OFS_CTL, 32'h0000_0005);
    rdc(OFS_STAT, 32'h0000_0000);
    wr(OFS_CTL, 32'h0000_0001);
    rdc(OFS_STAT, 32'h0000_4000);
  endtask

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    nrst = 1'b0;
    miscompares = 0;
    tests_run = 0;
    for (int i = 0; i < 8; i++)
      rxw[i] = 16'hFFFF;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_flags();
    t_ctx();
    t_crx();
    t_stop();
    complete_run();
  end
endmodule
`default_nettype wire
